// >>> hdl/cfdr_edge_sync.sv
// Three-stage synchroniser with rising edge pulse for an oscillator input
module cfdr_edge_sync (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic async_i,
  output logic      edge_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // Stages
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change accepted when second and third agree
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      level_q <= 1'b0;
      edge_o  <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      edge_o <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end

endmodule

// >>> hdl/cfdr_pkg.sv
// Package with register map, field layouts, states and timing for clock failure recovery
package cfdr_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] MASK_OFS  = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;

  // Clock source select codes
  typedef enum logic [1:0] {
    SRC_IOSC = 2'h0,
    SRC_PRI  = 2'h1,
    SRC_WDT  = 2'h2,
    SRC_EXT  = 2'h3
  } cfdr_src_t;

  // Control register layout, bit 0 first from the right
  typedef struct packed {
    cfdr_src_t clock_source_select;
    logic      wdtosc_on;
    logic      internal_precision_osc;
    logic      wdtosc_fail_detect_enable;
    logic      sysosc_fail_detect_enable;
  } cfdr_ctrl_t;

  localparam int CTRL_W          = 6;
  localparam int CTRL_SYSFD_BIT  = 0;
  localparam int CTRL_WDTFD_BIT  = 1;
  localparam int CTRL_IOSC_BIT   = 2;
  localparam int CTRL_WOSC_BIT   = 3;
  localparam int CTRL_SEL_LSB    = 4;
  localparam logic [5:0] CTRL_RST = 6'h0C;

  // Event layout shared by status and mask
  typedef struct packed {
    logic wdt_fail;
    logic sys_fail;
  } cfdr_ev_t;

  localparam int EV_W        = 2;
  localparam int EV_SYS_BIT  = 0;
  localparam int EV_WDT_BIT  = 1;
  localparam logic [1:0] EV_RST = 2'h0;

  // Recovery states
  typedef enum logic [2:0] {
    RS_WATCH    = 3'b001,
    RS_SWITCHED = 3'b010,
    RS_WDT_DEAD = 3'b100
  } cfdr_rs_t;

  // Timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int PRI_FAIL_HZ = 1000;
  localparam int PRI_LIMIT   = CLK_HZ / PRI_FAIL_HZ;
  localparam int WDT_LIMIT   = 8004;
  localparam int CNT_W       = 16;

  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

endpackage

// >>> hdl/cfdr_top.sv
// Clock failure detection and recovery with AHB-Lite registers
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
module cfdr_top #(
  parameter int PRI_LIMIT = cfdr_pkg::PRI_LIMIT,
  parameter int WDT_LIMIT = cfdr_pkg::WDT_LIMIT
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        PRI_OSC_I,
  input  wire logic        WDT_OSC_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [1:0]       CLK_SEL_O,
  output logic             IOSC_EN_O,
  output logic             WDTOSC_EN_O,
  output logic             NMI_O,
  output logic             IRQ_O
);

  cfdr_pkg::cfdr_ctrl_t ctrl_q;
  cfdr_pkg::cfdr_ev_t   stat_q;
  cfdr_pkg::cfdr_ev_t   stat_d;
  cfdr_pkg::cfdr_ev_t   mask_q;
  cfdr_pkg::cfdr_rs_t   rs_q;
  cfdr_pkg::cfdr_rs_t   rs_d;

  logic [cfdr_pkg::CNT_W-1:0] pri_cnt_q;
  logic [cfdr_pkg::CNT_W-1:0] wdt_cnt_q;
  logic                       pri_edge;
  logic                       wdt_edge;
  logic                       pri_run;
  logic                       sys_ev;
  logic                       wdt_ev;
  logic                       addr_ok;
  logic                       wr_pend_q;
  logic [7:0]                 wr_addr_q;
  logic                       wr_ctrl;
  logic                       wr_stat;
  logic                       wr_mask;
  logic [31:0]                rd_word;

  localparam logic [cfdr_pkg::CNT_W-1:0] PRI_LAST = cfdr_pkg::CNT_W'(PRI_LIMIT - 1);
  localparam logic [cfdr_pkg::CNT_W-1:0] PRI_SAT  = cfdr_pkg::CNT_W'(PRI_LIMIT);
  localparam logic [cfdr_pkg::CNT_W-1:0] WDT_LAST = cfdr_pkg::CNT_W'(WDT_LIMIT - 1);
  localparam logic [cfdr_pkg::CNT_W-1:0] WDT_SAT  = cfdr_pkg::CNT_W'(WDT_LIMIT);

  // Oscillator inputs into the system domain
  cfdr_edge_sync u_pri_sync (
    .CLK_I   (CLK_I),
    .RST_I   (RST_I),
    .async_i (PRI_OSC_I),
    .edge_o  (pri_edge)
  );

  cfdr_edge_sync u_wdt_sync (
    .CLK_I   (CLK_I),
    .RST_I   (RST_I),
    .async_i (WDT_OSC_I),
    .edge_o  (wdt_edge)
  );

  // Word address decode
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Read mux
  function automatic logic [31:0] read_word(input logic [31:0] a);
    logic [31:0] w;
    w = cfdr_pkg::WORD_ZERO;
    if (a[31:8] != 24'h00_0000) begin
      w = cfdr_pkg::WORD_ZERO;
    end else if (a[7:0] == cfdr_pkg::CTRL_OFS) begin
      w = {26'h000_0000, ctrl_q};
    end else if (a[7:0] == cfdr_pkg::STAT_OFS) begin
      w = {30'h0000_0000, stat_q};
    end else if (a[7:0] == cfdr_pkg::MASK_OFS) begin
      w = {30'h0000_0000, mask_q};
    end else if (a[7:0] == cfdr_pkg::STATE_OFS) begin
      w = {29'h0000_0000, rs_q};
    end
    return w;
  endfunction

  // Bus address phase
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
  assign rd_word = read_word(HADDR_I);
  assign wr_ctrl = wr_pend_q && reg_hit(wr_addr_q, cfdr_pkg::CTRL_OFS);
  assign wr_stat = wr_pend_q && reg_hit(wr_addr_q, cfdr_pkg::STAT_OFS);
  assign wr_mask = wr_pend_q && reg_hit(wr_addr_q, cfdr_pkg::MASK_OFS);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      HRDATA_O    <= cfdr_pkg::WORD_ZERO;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      wr_pend_q   <= addr_ok && HWRITE_I && (HADDR_I[31:8] == 24'h00_0000);
      wr_addr_q   <= HADDR_I[7:0];
      HRDATA_O    <= (addr_ok && !HWRITE_I) ? rd_word : cfdr_pkg::WORD_ZERO;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Primary oscillator watch counter
  assign pri_run = ctrl_q.sysosc_fail_detect_enable && (rs_q != cfdr_pkg::RS_WDT_DEAD);
  assign sys_ev  = pri_run && !pri_edge && (pri_cnt_q == PRI_LAST);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pri_cnt_q <= '0;
    end else if (!pri_run || pri_edge) begin
      pri_cnt_q <= '0;
    end else if (pri_cnt_q < PRI_SAT) begin
      pri_cnt_q <= pri_cnt_q + 1'b1;
    end
  end

  // Watchdog oscillator watch counter
  assign wdt_ev = ctrl_q.wdtosc_fail_detect_enable && !wdt_edge && (wdt_cnt_q == WDT_LAST);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wdt_cnt_q <= '0;
    end else if (!ctrl_q.wdtosc_fail_detect_enable || wdt_edge) begin
      wdt_cnt_q <= '0;
    end else if (wdt_cnt_q < WDT_SAT) begin
      wdt_cnt_q <= wdt_cnt_q + 1'b1;
    end
  end

  // Control register and automatic switch
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= cfdr_pkg::cfdr_ctrl_t'(cfdr_pkg::CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= cfdr_pkg::cfdr_ctrl_t'(HWDATA_I[cfdr_pkg::CTRL_W-1:0]);
      end
      if (sys_ev && ctrl_q.wdtosc_on) begin
        ctrl_q.clock_source_select <= cfdr_pkg::SRC_WDT;
      end
    end
  end

  // Sticky status, set wins over write-one clear
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~cfdr_pkg::cfdr_ev_t'(HWDATA_I[cfdr_pkg::EV_W-1:0]);
    end
    if (sys_ev) begin
      stat_d.sys_fail = 1'b1;
    end
    if (wdt_ev) begin
      stat_d.wdt_fail = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stat_q <= cfdr_pkg::cfdr_ev_t'(cfdr_pkg::EV_RST);
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask_q <= cfdr_pkg::cfdr_ev_t'(cfdr_pkg::EV_RST);
    end else if (wr_mask) begin
      mask_q <= cfdr_pkg::cfdr_ev_t'(HWDATA_I[cfdr_pkg::EV_W-1:0]);
    end
  end

  // Recovery state
  always_comb begin
    rs_d = rs_q;
    case (rs_q)
      cfdr_pkg::RS_WATCH: begin
        if (wdt_ev) begin
          rs_d = cfdr_pkg::RS_WDT_DEAD;
        end else if (sys_ev && ctrl_q.wdtosc_on) begin
          rs_d = cfdr_pkg::RS_SWITCHED;
        end
      end
      cfdr_pkg::RS_SWITCHED: begin
        if (wdt_ev) begin
          rs_d = cfdr_pkg::RS_WDT_DEAD;
        end else if (wr_ctrl && !(sys_ev && ctrl_q.wdtosc_on)) begin
          rs_d = cfdr_pkg::RS_WATCH;
        end
      end
      cfdr_pkg::RS_WDT_DEAD: begin
        rs_d = cfdr_pkg::RS_WDT_DEAD;
      end
      default: begin
        rs_d = cfdr_pkg::RS_WATCH;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rs_q <= cfdr_pkg::RS_WATCH;
    end else begin
      rs_q <= rs_d;
    end
  end

  // Output flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CLK_SEL_O   <= cfdr_pkg::SRC_IOSC;
      IOSC_EN_O   <= 1'b1;
      WDTOSC_EN_O <= 1'b1;
      NMI_O       <= 1'b0;
      IRQ_O       <= 1'b0;
    end else begin
      CLK_SEL_O   <= (sys_ev && ctrl_q.wdtosc_on) ? cfdr_pkg::SRC_WDT :
                     (wr_ctrl ? HWDATA_I[cfdr_pkg::CTRL_SEL_LSB +: 2] :
                      ctrl_q.clock_source_select);
      IOSC_EN_O   <= wr_ctrl ? HWDATA_I[cfdr_pkg::CTRL_IOSC_BIT] : ctrl_q.internal_precision_osc;
      WDTOSC_EN_O <= wr_ctrl ? HWDATA_I[cfdr_pkg::CTRL_WOSC_BIT] : ctrl_q.wdtosc_on;
      NMI_O       <= |stat_d;
      IRQ_O       <= |(stat_d & (wr_mask ? cfdr_pkg::cfdr_ev_t'(HWDATA_I[cfdr_pkg::EV_W-1:0]) :
                                 mask_q));
    end
  end

  // Helper for checks
  logic ctrl_written_q;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_written_q <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_int_osc_on: assert property (
    !ctrl_written_q |-> IOSC_EN_O
  ) else $error("Precision oscillator off without a write");

  a_int_osc_by_sw: assert property (
    (!wr_ctrl && !$past(wr_ctrl)) |=> $stable(IOSC_EN_O)
  ) else $error("Precision oscillator changed without a write");

  a_sys_fail_nmi: assert property (
    sys_ev |=> NMI_O && stat_q.sys_fail
  ) else $error("Primary failure did not raise the event");

  a_auto_switch_wdt: assert property (
    (sys_ev && ctrl_q.wdtosc_on) |=> (CLK_SEL_O == cfdr_pkg::SRC_WDT) &&
      (rs_q == cfdr_pkg::RS_SWITCHED || rs_q == cfdr_pkg::RS_WDT_DEAD)
  ) else $error("No switch to watchdog oscillator");

  a_no_switch_off: assert property (
    (sys_ev && !ctrl_q.wdtosc_on && !wr_ctrl) |=> $stable(CLK_SEL_O)
  ) else $error("Switched with watchdog oscillator off");

  a_pri_threshold: assert property (
    $rose(stat_q.sys_fail) |-> $past(pri_cnt_q) == PRI_LAST
  ) else $error("Primary failure at wrong count");

  a_wdt_keep_src: assert property (
    (wdt_ev && !sys_ev && !wr_ctrl) |=> $stable(CLK_SEL_O) && NMI_O
  ) else $error("Watchdog failure changed source or gave no event");

  a_dead_blind: assert property (
    (rs_q == cfdr_pkg::RS_WDT_DEAD) |-> !sys_ev ##1 pri_cnt_q == '0
  ) else $error("Primary detection active after watchdog failure");

  a_wdt_limit: assert property (
    $rose(stat_q.wdt_fail) |-> $past(wdt_cnt_q) == WDT_LAST
  ) else $error("Watchdog failure at wrong count");

  a_wdt_cnt_clear: assert property (
    (wdt_edge || !ctrl_q.wdtosc_fail_detect_enable) |=> wdt_cnt_q == '0
  ) else $error("Watchdog counter not cleared");

  a_pend_sticky: assert property (
    (stat_q.sys_fail && !(wr_stat && HWDATA_I[cfdr_pkg::EV_SYS_BIT])) |=> stat_q.sys_fail
  ) else $error("Pending primary failure lost");

  c_sys_fail: cover property (sys_ev);
  c_wdt_fail: cover property (wdt_ev);
  c_switched: cover property (rs_q == cfdr_pkg::RS_SWITCHED);
  c_irq:      cover property (IRQ_O);

endmodule

// >>> testbench/cfdr_osc_model.sv
// Behavioural oscillator source that can be stopped to mimic a failure
module cfdr_osc_model (
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc_o = 1'b0;
  // Toggles while running, a dead source freezes its level
  always begin
    #(half_i);
    if (run_i) osc_o = ~osc_o;
  end
endmodule

// >>> testbench/cfdr_tb_top.sv
// Self-checking bench for clock failure detection and recovery
module cfdr_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PL = 40;
  localparam int WL = 30;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        pri_run = 1'b1;
  logic        wdt_run = 1'b1;
  logic [7:0]  pri_half = 8'h50;
  logic [7:0]  wdt_half = 8'h60;
  logic        pri_osc, wdt_osc, rdy, resp, iosc, wosc, nmi, irq;
  logic [31:0] rdata, rd, d;
  logic [1:0]  sel;
  int          err_total = 0;
  int          checked = 0;
  int          n;

  always #25 clk = ~clk;

  cfdr_osc_model pri_u (.run_i(pri_run), .half_i(pri_half), .osc_o(pri_osc));
  cfdr_osc_model wdt_u (.run_i(wdt_run), .half_i(wdt_half), .osc_o(wdt_osc));

  cfdr_top #(.PRI_LIMIT(PL), .WDT_LIMIT(WL)) dut_u (
    .CLK_I(clk), .RST_I(rst), .PRI_OSC_I(pri_osc), .WDT_OSC_I(wdt_osc),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(rdata),
    .HREADYOUT_O(rdy), .HRESP_O(resp), .CLK_SEL_O(sel), .IOSC_EN_O(iosc),
    .WDTOSC_EN_O(wosc), .NMI_O(nmi), .IRQ_O(irq)
  );

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= cfdr_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = rdata;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk_reg(rd, exp);
    chk_pin({2'h0, rdy, resp}, 4'h2);
  endtask

  // Expected enable and select pins for a control value
  function automatic logic [3:0] ctrl_pins(input logic [5:0] v);
    return {v[2], v[3], v[5:4]};
  endfunction

  // Detectors go off in the same write that sets the source, then the full value
  task automatic set_ctrl(input logic [5:0] v);
    bus(1'b1, cfdr_pkg::CTRL_OFS, {26'h000_0000, v & 6'h3C});
    bus(1'b1, cfdr_pkg::CTRL_OFS, {26'h000_0000, v});
  endtask

  task automatic wait_nmi(input int lim);
    n = 0;
    while (nmi !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk_pin({3'h0, n >= lim - 8 && n <= lim + 8}, 4'h1);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    err_total++;
    report_and_stop();
  end

  initial begin
    void'($urandom(85114));
    pri_half = 8'(60 + $urandom % 100);
    wdt_half = 8'(60 + $urandom % 100);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_pin({iosc, wosc, sel}, 4'hC);
    chk_pin({2'h0, nmi, irq}, 4'h0);
    rd_chk(cfdr_pkg::CTRL_OFS, 32'h0000_000C);
    rd_chk(cfdr_pkg::STATE_OFS, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      bus(1'b1, cfdr_pkg::MASK_OFS, d);
      rd_chk(cfdr_pkg::MASK_OFS, d & 32'h0000_0003);
      bus(1'b1, 8'h10 + 8'(i * 4), d);
      rd_chk(8'h10 + 8'(i * 4), 32'h0000_0000);
    end
    bus(1'b1, cfdr_pkg::MASK_OFS, 32'h0000_0000);
    // Source change keeps the precision oscillator until cleared
    set_ctrl(6'h1C);
    chk_pin({iosc, wosc, sel}, ctrl_pins(6'h1C));
    set_ctrl(6'h18);
    chk_pin({iosc, wosc, sel}, ctrl_pins(6'h18));
    // Slow external source keeps primary detection off
    set_ctrl(6'h38);
    chk_pin({iosc, wosc, sel}, ctrl_pins(6'h38));
    // Primary failure with recovery
    set_ctrl(6'h1D);
    repeat (PL * 3) @(posedge clk);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0000);
    pri_run <= 1'b0;
    wait_nmi(PL);
    chk_pin({1'b0, nmi, sel}, 4'h6);
    rd_chk(cfdr_pkg::STATE_OFS, 32'h0000_0002);
    pri_run <= 1'b1;
    repeat (PL * 2) @(posedge clk);
    chk_pin({3'h0, nmi}, 4'h1);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0001);
    chk_pin({3'h0, irq}, 4'h0);
    bus(1'b1, cfdr_pkg::MASK_OFS, 32'h0000_0001);
    chk_pin({3'h0, irq}, 4'h1);
    bus(1'b1, cfdr_pkg::STAT_OFS, 32'h0000_0001);
    chk_pin({2'h0, nmi, irq}, 4'h0);
    // No switch while the watchdog oscillator is off
    set_ctrl(6'h15);
    pri_run <= 1'b0;
    wait_nmi(PL);
    chk_pin({1'b0, nmi, sel}, 4'h5);
    rd_chk(cfdr_pkg::STATE_OFS, 32'h0000_0001);
    pri_run <= 1'b1;
    repeat (20) @(posedge clk);
    bus(1'b1, cfdr_pkg::STAT_OFS, 32'h0000_0001);
    // Watchdog oscillator supervision
    set_ctrl(6'h1E);
    repeat (WL * 4) @(posedge clk);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0000);
    set_ctrl(6'h1C);
    wdt_run <= 1'b0;
    repeat (WL * 3) @(posedge clk);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0000);
    bus(1'b1, cfdr_pkg::CTRL_OFS, 32'h0000_001E);
    wait_nmi(WL);
    chk_pin({1'b0, nmi, sel}, 4'h5);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0002);
    rd_chk(cfdr_pkg::STATE_OFS, 32'h0000_0004);
    bus(1'b1, cfdr_pkg::STAT_OFS, 32'h0000_0002);
    // Primary loss goes unseen once the watchdog source is dead
    bus(1'b1, cfdr_pkg::CTRL_OFS, 32'h0000_0015);
    pri_run <= 1'b0;
    repeat (PL * 3) @(posedge clk);
    rd_chk(cfdr_pkg::STAT_OFS, 32'h0000_0000);
    chk_pin({1'b0, nmi, sel}, 4'h1);
    report_and_stop();
  end
endmodule
